// >>> hdl/cocr_map.vh
// register offsets, field positions and reset values of the combiner block
`ifndef COCR_MAP_VH
`define COCR_MAP_VH

// register indices; byte address is four times the index
`define COCR_IDX_M3_LSB_BASE 7'h21
`define COCR_IDX_M3_MSB_BASE 7'h22
`define COCR_IDX_I_PWR_BASE  7'h23
`define COCR_IDX_Q_PWR_BASE  7'h24
`define COCR_BLK_STRIDE      7'h08
`define COCR_NUM_BLK         4
`define COCR_IDX_OUT_CFG     7'h40
`define COCR_IDX_GAIN        7'h41
`define COCR_IDX_M4_LSB      7'h42
`define COCR_IDX_M4_MSB      7'h43
`define COCR_IDX_TEST_VALUE  7'h4e
`define COCR_IDX_SIGNATURE   7'h4f

// output test and configuration field positions
`define COCR_CFG_INVERT_BIT  13
`define COCR_CFG_XCLK_BIT    12
`define COCR_CFG_SDIV_HI     11
`define COCR_CFG_SDIV_LO     10
`define COCR_CFG_SEL_HI      9
`define COCR_CFG_SEL_LO      8
`define COCR_CFG_SPARE_BIT   3
`define COCR_CFG_XOR_BIT     2
`define COCR_CFG_SYNC_BIT    1
`define COCR_CFG_LOAD_BIT    0

// output test select encodings
`define COCR_SEL_BYPASS      2'h0
`define COCR_SEL_SIGNATURE   2'h1
`define COCR_SEL_PATTERN     2'h2
`define COCR_SEL_REGVALUE    2'h3

// signature sampling divisors, one per encoding
`define COCR_SDIV_0          4'hc
`define COCR_SDIV_1          4'h9
`define COCR_SDIV_2          4'ha
`define COCR_SDIV_3          4'hb

// reset values
`define COCR_RST_OUT_CFG     16'h0002
`define COCR_RST_GAIN        9'h0ff
`define COCR_LFSR_SEED       15'h7fff
`define COCR_SIG_SEED        16'h0000

// widths
`define COCR_M3_MSB_W        4
`define COCR_M3_W            20
`define COCR_M4_MSB_W        5
`define COCR_M4_W            21
`define COCR_PWR_W           12
`define COCR_GAIN_W          9

`endif

// >>> hdl/cocr_signature.v
// signature analyser with selectable sampling divider
`timescale 1ns/1ps
`include "cocr_map.vh"

module cocr_signature
#(
  parameter SIG_W = 16                   // signature width
)
(
  input  wire             core_clk_in,   // data clock
  input  wire             rst_in,        // sync reset, active high
  input  wire             enable_in,     // analyser running
  input  wire [1:0]       div_sel_in,    // sampling divider select
  input  wire [SIG_W-1:0] data_in,       // word to compress
  output reg  [SIG_W-1:0] signature_out  // current signature
);

  reg [3:0] div_cnt_r;                   // sample divider count
  reg [3:0] div_max;                     // divisor minus one
  wire      sample;                      // sampling strike

  // divider select decode
  always @*
  begin
    case (div_sel_in)
      2'h0:    div_max = `COCR_SDIV_0 - 4'h1;
      2'h1:    div_max = `COCR_SDIV_1 - 4'h1;
      2'h2:    div_max = `COCR_SDIV_2 - 4'h1;
      default: div_max = `COCR_SDIV_3 - 4'h1;
    endcase
  end

  // strike when count wraps; >= guards a divisor shrinking mid-count
  assign sample = (div_cnt_r >= div_max);

  // divider and multiple-input shift register
  always @(posedge core_clk_in)
  begin
    if (rst_in || !enable_in)
    begin
      div_cnt_r     <= 4'h0;
      signature_out <= `COCR_SIG_SEED;
    end
    else if (sample)
    begin
      div_cnt_r     <= 4'h0;
      signature_out <= {signature_out[SIG_W-2:0],
                        signature_out[SIG_W-1] ^ signature_out[SIG_W-3]}
                       ^ data_in;
    end
    else
      div_cnt_r <= div_cnt_r + 4'h1;
  end

endmodule

// >>> hdl/cocr_regs.v
// combiner output control registers with avalon-mm slave and output stage
// Operation
// - upper block register holds word bits 19:16
// - four upper registers, base 0x022, stride 8
// - I-path twelve-bit power count per block
// - Q-path twelve-bit power count per block
// - complement bit inverts B and D outputs
// - clock-out bit drives data clock over sixteen
// - sampling divider: 12, 9, 10, 11
// - test select: bypass, signature, pattern, value
// - scramble bit modulates outputs with LFSR
// - sync bit starts LFSR on sync event
// - load bit pulses then clears itself
// - combiner gain unsigned, low eight reset ones
// - register 0x042 holds mod4 word low sixteen
// - lower block register holds word bits 15:0
// - separate register holds mod4 bits 20:16
`timescale 1ns/1ps
`include "cocr_map.vh"

module cocr_regs
#(
  parameter DATA_W = 14                        // width of each output port
)
(
  input  wire               core_clk_in,       // data clock, 10 MHz
  input  wire               rst_in,            // sync reset, active high
  // avalon-mm slave, byte addressed
  input  wire [8:0]         avs_address_in,    // byte address
  input  wire               avs_read_in,       // read request
  input  wire               avs_write_in,      // write request
  input  wire [31:0]        avs_writedata_in,  // write data
  input  wire [3:0]         avs_byteenable_in, // byte lanes
  output reg  [31:0]        avs_readdata_out,  // read data
  output wire               avs_waitrequest_out, // stall
  // power monitor counts from the block combiners, 12 bits each
  input  wire [47:0]        i_power_count_in,  // I path, block 1 lowest
  input  wire [47:0]        q_power_count_in,  // Q path, block 1 lowest
  // output datapath
  input  wire               sync_in,           // sync event pulse
  input  wire [DATA_W-1:0]  port_b_in,         // B data from combiner
  input  wire [DATA_W-1:0]  port_d_in,         // D data from combiner
  output reg  [DATA_W-1:0]  port_b_out,        // B output port
  output reg  [DATA_W-1:0]  port_d_out,        // D output port
  // active oscillator words and gain
  output reg  [79:0]        mod3_freq_word_out, // 4 x 20, block 1 lowest
  output reg  [20:0]        mod4_freq_word_out, // modulator-4 word
  output reg                freq_word_load_out, // one-cycle load strobe
  output wire [8:0]         combiner_gain_out   // 128-channel gain
);

  localparam NB = `COCR_NUM_BLK;               // block count

  // register storage
  reg  [15:0] m3_lsb_r [0:NB-1];               // staged mod3 low parts
  reg  [3:0]  m3_msb_r [0:NB-1];               // staged mod3 high parts
  reg  [11:0] i_pwr_r  [0:NB-1];               // captured I counts
  reg  [11:0] q_pwr_r  [0:NB-1];               // captured Q counts
  reg  [15:0] out_cfg_r;                       // output test config
  reg  [8:0]  gain_r;                          // combiner gain
  reg  [15:0] m4_lsb_r;                        // staged mod4 low part
  reg  [4:0]  m4_msb_r;                        // staged mod4 high part
  reg  [15:0] test_value_r;                    // value for select 11
  reg         ack_r;                           // answer phase flag

  // output path state
  reg  [14:0] lfsr_r;                          // scramble generator
  reg         synced_r;                        // sync seen since enable
  reg  [3:0]  clk_div_r;                       // divide-by-sixteen count
  reg         toggle_r;                        // data/clock pattern bit
  wire [15:0] signature;                       // analyser state

  // bus decode
  wire [6:0]  idx = avs_address_in[8:2];       // register index
  wire        req = avs_read_in | avs_write_in; // any request
  wire        wr_go = avs_write_in & ack_r;    // write commit edge
  integer     k;                               // loop index, register writes
  integer     kp;                              // loop index, power counts
  integer     kr;                              // loop index, read mux
  integer     kw;                              // loop index, word transfer

  // config fields
  wire        cfg_invert = out_cfg_r[`COCR_CFG_INVERT_BIT];
  wire        cfg_xclk   = out_cfg_r[`COCR_CFG_XCLK_BIT];
  wire [1:0]  cfg_sdiv   = out_cfg_r[`COCR_CFG_SDIV_HI:`COCR_CFG_SDIV_LO];
  wire [1:0]  cfg_sel    = out_cfg_r[`COCR_CFG_SEL_HI:`COCR_CFG_SEL_LO];
  wire        cfg_xor    = out_cfg_r[`COCR_CFG_XOR_BIT];
  wire        cfg_sync   = out_cfg_r[`COCR_CFG_SYNC_BIT];
  wire        cfg_load   = out_cfg_r[`COCR_CFG_LOAD_BIT];

  // true when idx addresses the per-block register base of block b
  function blk_hit;
    input [6:0] a;
    input [6:0] base;
    input integer b;
    begin
      blk_hit = (a == base + b[6:0] * `COCR_BLK_STRIDE);
    end
  endfunction

  // byte-lane merge for a 16-bit register image
  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  be;
    begin
      lane_merge = {be[1] ? nw[15:8] : old[15:8],
                    be[0] ? nw[7:0]  : old[7:0]};
    end
  endfunction

  // one wait cycle then answer; read data is ready by then
  assign avs_waitrequest_out = req & ~ack_r;

  // answer phase: set on the first cycle of a request, then drop
  always @(posedge core_clk_in)
  begin
    if (rst_in)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  // software-written registers
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      for (k = 0; k < NB; k = k + 1)
      begin
        m3_lsb_r[k] <= 16'h0000;
        m3_msb_r[k] <= 4'h0;
      end
      out_cfg_r    <= `COCR_RST_OUT_CFG;
      gain_r       <= `COCR_RST_GAIN;
      m4_lsb_r     <= 16'h0000;
      m4_msb_r     <= 5'h00;
      test_value_r <= 16'h0000;
    end
    else
    begin
      // load bit drops one cycle after it was written
      if (cfg_load)
        out_cfg_r[`COCR_CFG_LOAD_BIT] <= 1'b0;
      if (wr_go)
      begin
        for (k = 0; k < NB; k = k + 1)
        begin
          if (blk_hit(idx, `COCR_IDX_M3_LSB_BASE, k))
            m3_lsb_r[k] <= lane_merge(m3_lsb_r[k],
                             avs_writedata_in[15:0], avs_byteenable_in[1:0]);
          if (blk_hit(idx, `COCR_IDX_M3_MSB_BASE, k) && avs_byteenable_in[0])
            m3_msb_r[k] <= avs_writedata_in[3:0];
        end
        // power count offsets fall through: no storage to write
        case (idx)
          `COCR_IDX_OUT_CFG:
            out_cfg_r <= lane_merge(out_cfg_r, avs_writedata_in[15:0],
                                    avs_byteenable_in[1:0]) &
                         16'h3f0f;                 // reserved bits stay 0
          `COCR_IDX_GAIN:
          begin
            if (avs_byteenable_in[0])
              gain_r[7:0] <= avs_writedata_in[7:0];
            if (avs_byteenable_in[1])
              gain_r[8] <= avs_writedata_in[8];
          end
          `COCR_IDX_M4_LSB:
            m4_lsb_r <= lane_merge(m4_lsb_r, avs_writedata_in[15:0],
                                   avs_byteenable_in[1:0]);
          `COCR_IDX_M4_MSB:
            if (avs_byteenable_in[0])
              m4_msb_r <= avs_writedata_in[4:0];
          `COCR_IDX_TEST_VALUE:
            test_value_r <= lane_merge(test_value_r, avs_writedata_in[15:0],
                                       avs_byteenable_in[1:0]);
          default:
            test_value_r <= test_value_r;           // unmapped: ignored
        endcase
      end
    end
  end

  // power counts sampled every cycle; software only ever reads them
  always @(posedge core_clk_in)
  begin
    for (kp = 0; kp < NB; kp = kp + 1)
    begin
      if (rst_in)
      begin
        i_pwr_r[kp] <= 12'h000;
        q_pwr_r[kp] <= 12'h000;
      end
      else
      begin
        i_pwr_r[kp] <= i_power_count_in[kp*12 +: 12];
        q_pwr_r[kp] <= q_power_count_in[kp*12 +: 12];
      end
    end
  end

  // read mux, captured on the first request cycle and held for the answer
  always @(posedge core_clk_in)
  begin
    if (rst_in)
      avs_readdata_out <= 32'h0000_0000;
    else if (avs_read_in && !ack_r)
    begin
      // unmapped reads zero; per-block hits below override the default
      case (idx)
        `COCR_IDX_OUT_CFG:    avs_readdata_out <= {16'h0000, out_cfg_r};
        `COCR_IDX_GAIN:       avs_readdata_out <= {23'h000000, gain_r};
        `COCR_IDX_M4_LSB:     avs_readdata_out <= {16'h0000, m4_lsb_r};
        `COCR_IDX_M4_MSB:     avs_readdata_out <= {27'h0000000, m4_msb_r};
        `COCR_IDX_TEST_VALUE: avs_readdata_out <= {16'h0000, test_value_r};
        `COCR_IDX_SIGNATURE:  avs_readdata_out <= {16'h0000, signature};
        default:              avs_readdata_out <= 32'h0000_0000;
      endcase
      for (kr = 0; kr < NB; kr = kr + 1)
      begin
        if (blk_hit(idx, `COCR_IDX_M3_LSB_BASE, kr))
          avs_readdata_out <= {16'h0000, m3_lsb_r[kr]};
        if (blk_hit(idx, `COCR_IDX_M3_MSB_BASE, kr))
          avs_readdata_out <= {28'h0000000, m3_msb_r[kr]};
        if (blk_hit(idx, `COCR_IDX_I_PWR_BASE, kr))
          avs_readdata_out <= {20'h00000, i_pwr_r[kr]};
        if (blk_hit(idx, `COCR_IDX_Q_PWR_BASE, kr))
          avs_readdata_out <= {20'h00000, q_pwr_r[kr]};
      end
    end
  end

  assign combiner_gain_out = gain_r;           // unsigned gain

  // active words: all parts move together on the load pulse, so the
  // oscillators never see a half-written word
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      mod3_freq_word_out <= 80'h0;
      mod4_freq_word_out <= 21'h000000;
      freq_word_load_out <= 1'b0;
    end
    else
    begin
      freq_word_load_out <= cfg_load;
      if (cfg_load)
      begin
        for (kw = 0; kw < NB; kw = kw + 1)
          mod3_freq_word_out[kw*20 +: 20] <=
            {m3_msb_r[kw], m3_lsb_r[kw]};
        mod4_freq_word_out <= {m4_msb_r, m4_lsb_r};
      end
    end
  end

  // scramble generator, x^15 + x^14 + 1; sync restarts it from seed
  always @(posedge core_clk_in)
  begin
    if (rst_in || !cfg_xor)
    begin
      lfsr_r   <= `COCR_LFSR_SEED;
      synced_r <= 1'b0;
    end
    else if (cfg_sync && sync_in)
    begin
      lfsr_r   <= `COCR_LFSR_SEED;
      synced_r <= 1'b1;
    end
    else
      lfsr_r <= {lfsr_r[13:0], lfsr_r[14] ^ lfsr_r[13]};
  end

  // free-running divider for the clock-out path and the test toggle
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      clk_div_r <= 4'h0;
      toggle_r  <= 1'b0;
    end
    else
    begin
      clk_div_r <= clk_div_r + 4'h1;           // msb is clock / 16
      toggle_r  <= ~toggle_r;
    end
  end

  // signature analyser sees both ports, folded to sixteen bits
  cocr_signature #(
    .SIG_W         (16)
  ) u_sig (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .enable_in     (cfg_sel == `COCR_SEL_SIGNATURE),
    .div_sel_in    (cfg_sdiv),
    .data_in       ({2'h0, port_b_in} ^ {port_d_in, 2'h0}),
    .signature_out (signature)
  );

  // xor mask: clock-out overrides scramble; scramble waits for sync
  // when the sync bit is set, so the far end can align its descrambler
  reg              scr_on;                     // scramble active
  reg [DATA_W-1:0] mask;                       // xor mask
  reg [DATA_W-1:0] b_sel;                      // B before invert
  reg [DATA_W-1:0] d_sel;                      // D before invert
  always @*
  begin
    scr_on = cfg_xor && (!cfg_sync || synced_r);
    if (cfg_xclk)
      mask = {DATA_W{clk_div_r[3]}};
    else if (scr_on)
      mask = {DATA_W{lfsr_r[0]}} ^ lfsr_r[DATA_W-1:0];
    else
      mask = {DATA_W{1'b0}};
    case (cfg_sel)
      `COCR_SEL_BYPASS:
      begin
        b_sel = port_b_in;
        d_sel = port_d_in;
      end
      `COCR_SEL_SIGNATURE:
      begin
        b_sel = signature[DATA_W-1:0];
        d_sel = signature[15:16-DATA_W];
      end
      `COCR_SEL_PATTERN:
      begin
        b_sel = {DATA_W{toggle_r}};
        d_sel = {DATA_W{~toggle_r}};
      end
      default:
      begin
        b_sel = test_value_r[DATA_W-1:0];
        d_sel = test_value_r[DATA_W-1:0];
      end
    endcase
  end

  // output registers: mask, then optional complement of B and D
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      port_b_out <= {DATA_W{1'b0}};
      port_d_out <= {DATA_W{1'b0}};
    end
    else if (cfg_invert)
    begin
      port_b_out <= ~(b_sel ^ mask);
      port_d_out <= ~(d_sel ^ mask);
    end
    else
    begin
      port_b_out <= b_sel ^ mask;
      port_d_out <= d_sel ^ mask;
    end
  end

endmodule

// >>> test/cocr_regs_props.sv
// checker for the combiner register block, bound to cocr_regs
`timescale 1ns/1ps
module cocr_regs_props
#(
  parameter DATA_W = 14                  // output port width
)
(
  input wire              core_clk_in,   // data clock
  input wire              rst_in,        // sync reset
  input wire [8:0]        avs_address_in,
  input wire              avs_read_in,
  input wire              avs_write_in,
  input wire [31:0]       avs_writedata_in,
  input wire [3:0]        avs_byteenable_in,
  input wire [31:0]       avs_readdata_out,
  input wire              avs_waitrequest_out,
  input wire [47:0]       i_power_count_in,
  input wire [DATA_W-1:0] port_b_in,
  input wire [DATA_W-1:0] port_b_out,
  input wire [79:0]       mod3_freq_word_out,
  input wire [20:0]       mod4_freq_word_out,
  input wire              freq_word_load_out,
  input wire [8:0]        combiner_gain_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire [6:0] idx = avs_address_in[8:2];   // register index
  wire       rd_ok = avs_read_in && !avs_waitrequest_out;
  wire       cfg_wr = avs_write_in && !avs_waitrequest_out && idx == 7'h40;
  reg  [7:0] cfg_hi_r;                    // shadow of cfg bits 15:8
  reg        scr_r;                       // shadow of scramble bit
  reg  [1:0] quiet_r;                     // cycles since last cfg write
  // shadow cfg; quiet lets the registered output path settle first
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      cfg_hi_r <= 8'h00;
      scr_r    <= 1'b0;
      quiet_r  <= 2'h0;
    end
    else if (cfg_wr)
    begin
      if (avs_byteenable_in[1]) cfg_hi_r <= avs_writedata_in[15:8];
      if (avs_byteenable_in[0]) scr_r <= avs_writedata_in[2];
      quiet_r <= 2'h0;
    end
    else if (quiet_r != 2'h3)
      quiet_r <= quiet_r + 2'h1;
  end
  wire plain = quiet_r == 2'h3 && cfg_hi_r[1:0] == 2'h0 && !cfg_hi_r[4];
  property p_wait;
    (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out;
  endproperty
  property p_load_cause;
    cfg_wr && avs_byteenable_in[0] && avs_writedata_in[0]
      |-> ##2 freq_word_load_out;
  endproperty
  property p_load_pulse;
    freq_word_load_out |=> !freq_word_load_out;
  endproperty
  property p_words;
    $changed(mod3_freq_word_out) || $changed(mod4_freq_word_out)
      |-> freq_word_load_out;
  endproperty
  property p_gain_rst;
    $fell(rst_in) |-> combiner_gain_out == 9'h0ff;
  endproperty
  property p_pwr;
    rd_ok && idx == 7'h23
      |-> avs_readdata_out[11:0] == $past(i_power_count_in[11:0], 2);
  endproperty
  property p_msb;
    rd_ok && idx >= 7'h22 && idx <= 7'h3a && idx[2:0] == 3'h2
      |-> avs_readdata_out[31:4] == 28'h0;
  endproperty
  property p_bypass;
    plain && !scr_r |-> port_b_out ==
      (cfg_hi_r[5] ? ~$past(port_b_in) : $past(port_b_in));
  endproperty
  property p_clkout;
    quiet_r == 2'h3 && cfg_hi_r[4] && cfg_hi_r[1:0] == 2'h0 &&
      !cfg_hi_r[5] && $past(port_b_in) == 0
      |-> port_b_out == 0 || port_b_out == {DATA_W{1'b1}};
  endproperty
  a_wait: assert property (p_wait) else $error("wait not one cycle");
  a_load_cause: assert property (p_load_cause) else $error("no load");
  a_load_pulse: assert property (p_load_pulse) else $error("long load");
  a_words: assert property (p_words) else $error("word moved");
  a_gain_rst: assert property (p_gain_rst) else $error("gain reset");
  a_pwr: assert property (p_pwr) else $error("i count read");
  a_msb: assert property (p_msb) else $error("upper bits set");
  a_bypass: assert property (p_bypass) else $error("bypass data");
  a_clkout: assert property (p_clkout) else $error("clock out");
  c_load: cover property (freq_word_load_out);
  c_pwr: cover property (rd_ok && idx == 7'h23);
  c_clk: cover property (quiet_r == 2'h3 && cfg_hi_r[4]);
endmodule
bind cocr_regs cocr_regs_props #(.DATA_W(DATA_W)) u_props
(
  .core_clk_in(core_clk_in), .rst_in(rst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .i_power_count_in(i_power_count_in), .port_b_in(port_b_in),
  .port_b_out(port_b_out), .mod3_freq_word_out(mod3_freq_word_out),
  .mod4_freq_word_out(mod4_freq_word_out),
  .freq_word_load_out(freq_word_load_out),
  .combiner_gain_out(combiner_gain_out)
);

// >>> test/cocr_regs_tb.sv
// self-checking bench for the combiner register block
`timescale 1ns/1ps
module cocr_regs_tb;
  reg         clk = 1'b0;        // 10 MHz
  reg         rst = 1'b1;        // sync reset
  reg  [8:0]  addr = 9'h000;     // bus request signals
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [31:0] wdat = 32'h0;
  reg  [47:0] ipc = 48'h0;       // power counts
  reg  [47:0] qpc = 48'h0;
  reg         sync = 1'b0;
  reg  [13:0] bin = 14'h0;       // port data
  reg  [13:0] din = 14'h0;
  wire [31:0] rdat;
  wire        wreq;
  wire [13:0] bout;
  wire [13:0] dout;
  wire [79:0] m3;
  wire [20:0] m4;
  wire        ld;
  wire [8:0]  gain;
  integer     mismatches = 0;
  integer     cmp_count = 0;
  reg  [31:0] r;                 // last read value
  cocr_regs dut
  (
    .core_clk_in(clk), .rst_in(rst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(4'h3), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .i_power_count_in(ipc),
    .q_power_count_in(qpc), .sync_in(sync), .port_b_in(bin),
    .port_d_in(din), .port_b_out(bout), .port_d_out(dout),
    .mod3_freq_word_out(m3), .mod4_freq_word_out(m4),
    .freq_word_load_out(ld), .combiner_gain_out(gain)
  );
  initial forever #50 clk = ~clk;
  task give_verdict;
  begin
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // one avalon transfer; request held until waitrequest is seen low
  task bus(input is_rd, input [6:0] idx, input [15:0] d);
    integer n;
  begin
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd <= is_rd;
    wr <= !is_rd;
    wdat <= {16'h0, d};
    n = 0;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n = n + 1;
    end
    if (n >= 50)
      mismatches = mismatches + 1;
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  end
  endtask
  task cyc(input integer n);
  begin
    repeat (n) @(negedge clk);
  end
  endtask
  task t_reset;
  begin
    bus(1, 7'h40, 0); chk(r, 32'h0002);
    bus(1, 7'h41, 0); chk(r, 32'h00ff);
    bus(1, 7'h7f, 0); chk(r, 32'h0);
    bus(0, 7'h41, 16'hffff); bus(1, 7'h41, 0);
    chk(r, 32'h01ff);
    chk(gain, 9'h1ff);
  end
  endtask
  // staged words reach the oscillators only on the load pulse
  task t_words;
    integer n;
  begin
    for (n = 0; n < 4; n = n + 1)
    begin
      bus(0, 7'h21 + 8 * n, 16'ha5c0 + n);
      bus(0, 7'h22 + 8 * n, 16'hfff0 | (n + 9));
      bus(1, 7'h22 + 8 * n, 0); chk(r, n + 9);
    end
    bus(0, 7'h42, 16'h1234); bus(0, 7'h43, 16'hffff);
    chk(m3[31:0], 32'h0); chk(m4, 21'h0);
    bus(0, 7'h40, 16'h0003);
    n = 0;
    while (ld !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n = n + 1;
    end
    for (n = 0; n < 4; n = n + 1)
      chk(m3[20*n +: 20], {n[3:0] + 4'h9, 16'ha5c0 + n[15:0]});
    chk(m4, {5'h1f, 16'h1234});
    bus(1, 7'h40, 0); chk(r, 32'h0002);
  end
  endtask
  task t_pwr;
    integer n;
  begin
    ipc <= 48'h123_abc_456_789;
    qpc <= 48'hfed_321_0a5_5a0;
    cyc(3);
    for (n = 0; n < 4; n = n + 1)
    begin
      bus(0, 7'h23 + 8 * n, 16'h0000);
      bus(1, 7'h23 + 8 * n, 0); chk(r, ipc[12*n +: 12]);
      bus(0, 7'h24 + 8 * n, 16'hffff);
      bus(1, 7'h24 + 8 * n, 0); chk(r, qpc[12*n +: 12]);
    end
  end
  endtask
  // output path: invert, test value, pattern, clock out, scramble
  task t_out;
    reg [13:0] last;
    reg [13:0] acc;
    integer    n;
  begin
    bin <= 14'h1234;
    din <= 14'h0abc;
    bus(0, 7'h40, 16'h2000); cyc(3);
    chk(bout, 14'h1234 ^ 14'h3fff);
    chk(dout, 14'h0abc ^ 14'h3fff);
    bus(0, 7'h4e, 16'h2abc); bus(0, 7'h40, 16'h0300); cyc(3);
    chk(bout, 14'h2abc); chk(dout, 14'h2abc);
    bus(0, 7'h40, 16'h0200); cyc(3);
    last = bout; cyc(1);
    chk(bout, last ^ 14'h3fff);
    chk(dout, bout ^ 14'h3fff);
    bin <= 14'h0;
    din <= 14'h0;
    bus(0, 7'h40, 16'h1000); cyc(3);
    for (n = 0; n < 2; n = n + 1)
    begin
      last = bout;
      acc = 0;
      while (bout === last && acc < 20)
      begin
        @(negedge clk);
        acc = acc + 1;
      end
    end
    chk(acc, 8);
    chk(bout, last ^ 14'h3fff);
    bus(0, 7'h40, 16'h0006); cyc(5);
    chk(bout, 14'h0);
    @(posedge clk) sync <= 1'b1;
    @(posedge clk) sync <= 1'b0;
    acc = 0;
    for (n = 0; n < 16; n = n + 1)
    begin
      @(negedge clk);
      acc = acc | bout;
    end
    chk(acc != 0, 1);
    // scramble with the sync bit clear runs without waiting for sync
    bus(0, 7'h40, 16'h0000);
    bus(0, 7'h40, 16'h0004);
    acc = 0;
    for (n = 0; n < 16; n = n + 1)
    begin
      @(negedge clk);
      acc = acc | bout;
    end
    chk(acc != 0, 1);
  end
  endtask
  // every sampling divider code keeps the analyser moving
  task t_sig;
    reg [31:0] s0;
    reg [13:0] last;
    integer    n;
    integer    k;
    integer    acc;
  begin
    for (n = 0; n < 4; n = n + 1)
    begin
      bin <= 14'h0155 + n;
      bus(0, 7'h40, 16'h0100 | (n << 10));
      bus(1, 7'h4f, 0); s0 = r;
      cyc(30);
      bin <= 14'h2aa0 + n;
      cyc(30);
      bus(1, 7'h4f, 0); chk(r != s0, 1);
      // port B carries the signature, which moves once per sample period
      for (k = 0; k < 2; k = k + 1)
      begin
        last = bout;
        acc = 0;
        while (bout === last && acc < 20)
        begin
          @(negedge clk);
          acc = acc + 1;
        end
      end
      chk(acc, (n == 0) ? 12 : n + 8);
    end
  end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk(gain, 9'h0ff);
    t_reset;
    t_words;
    t_pwr;
    t_out;
    t_sig;
    give_verdict;
  end
  initial
  begin
    #1000000;
    mismatches = mismatches + 1;
    give_verdict;
  end
endmodule
